// >>> core/gpio_port_cfg.svh
// register offsets, reset values and port constants of the general purpose io port
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH
`define GP_OFF_LATCH 12'h000
`define GP_OFF_SET 12'h004
`define GP_OFF_CLEAR 12'h008
`define GP_OFF_TOGGLE 12'h00C
`define GP_OFF_INPUT 12'h010
`define GP_OFF_DIR 12'h014
`define GP_ADDR_W 12
`define GP_REG_RESET 32'h00000000
`define GP_PIN_IMPL 32'hFFFFFFFF
`define GP_OE_N_RESET 32'hFFFFFFFF
`define GP_RESP_OKAY 2'h0
`define GP_RESP_SLVERR 2'h2
`endif

// >>> core/gpio_port_pkg.sv
// types shared by the general purpose io port modules
package gpio_port_pkg;
   typedef logic [31:0] word_t;
   typedef logic [11:0] addr_t;
   typedef logic [1:0] resp_t;
   typedef enum logic [2:0] {
      op_none = 3'h0,
      op_write = 3'h1,
      op_set = 3'h2,
      op_clear = 3'h3,
      op_toggle = 3'h4
   } latch_op_e;
endpackage

// >>> core/latch_cmd_if.sv
// interface carrying latch update commands between bus slave and port core
`timescale 1ns/10ps
interface latch_cmd_if;
   import gpio_port_pkg::*;
   latch_op_e op;
   word_t data;
   logic dir_we;
   word_t latch_q;
   word_t dir_q;
   word_t input_q;
   modport slave (output op, output data, output dir_we, input latch_q, input dir_q, input input_q);
   modport core (input op, input data, input dir_we, output latch_q, output dir_q, output input_q);
endinterface

// >>> core/gpio_axil_slave.sv
// axi4-lite slave that decodes port register accesses into latch commands
`timescale 1ns/10ps
`include "gpio_port_cfg.svh"
module gpio_axil_slave (
   input wire logic aclk,
   input wire logic aresetn,
   input wire gpio_port_pkg::addr_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire gpio_port_pkg::word_t wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output gpio_port_pkg::resp_t bresp,
   output logic bvalid,
   input wire logic bready,
   input wire gpio_port_pkg::addr_t araddr,
   input wire logic arvalid,
   output logic arready,
   output gpio_port_pkg::word_t rdata,
   output gpio_port_pkg::resp_t rresp,
   output logic rvalid,
   input wire logic rready,
   latch_cmd_if.slave cmd
);
   import gpio_port_pkg::*;

   addr_t aw_addr_ff;
   logic aw_have_ff;
   word_t w_data_ff;
   logic [3:0] w_strb_ff;
   logic w_have_ff;
   logic do_write;
   logic nxt_aw_have;
   logic nxt_w_have;
   logic nxt_bvalid;
   logic nxt_rvalid;

   // merge written lanes over the old value
   function automatic word_t lane_merge(input word_t old_v, input word_t new_v, input logic [3:0] strb);
      word_t res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // offset is one of the mapped registers
   function automatic logic is_mapped(input addr_t a);
      return a == `GP_OFF_LATCH || a == `GP_OFF_SET || a == `GP_OFF_CLEAR || a == `GP_OFF_TOGGLE ||
             a == `GP_OFF_INPUT || a == `GP_OFF_DIR;
   endfunction

   assign do_write = aw_have_ff && w_have_ff && !bvalid;

   // capture address and data independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_addr_ff <= 12'h000;
         w_data_ff <= `GP_REG_RESET;
         w_strb_ff <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_have_ff <= 1'b1;
            aw_addr_ff <= awaddr;
         end else if (do_write) begin
            aw_have_ff <= 1'b0;
         end
         if (wvalid && wready) begin
            w_have_ff <= 1'b1;
            w_data_ff <= wdata;
            w_strb_ff <= wstrb;
         end else if (do_write) begin
            w_have_ff <= 1'b0;
         end
      end
   end

   // next channel state, used to register the ready flags
   assign nxt_aw_have = (awvalid && awready) || (aw_have_ff && !do_write);
   assign nxt_w_have = (wvalid && wready) || (w_have_ff && !do_write);
   assign nxt_bvalid = do_write || (bvalid && !bready);
   assign nxt_rvalid = (arvalid && arready) || (rvalid && !rready);

   // ready flags come straight from flops so the top outputs stay registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         arready <= 1'b1;
      end else begin
         awready <= !nxt_aw_have && !nxt_bvalid;
         wready <= !nxt_w_have && !nxt_bvalid;
         arready <= !nxt_rvalid;
      end
   end

   // write response, error for unmapped offsets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid <= 1'b0;
         bresp <= `GP_RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= is_mapped(aw_addr_ff) ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // issue at most one latch command per accepted write, none for direction, input or unmapped offsets; byte lanes mask alias bits
   always_comb begin
      cmd.op = op_none;
      cmd.data = lane_merge(32'h00000000, w_data_ff, w_strb_ff);
      cmd.dir_we = 1'b0;
      if (do_write) begin
         unique case (aw_addr_ff)
            `GP_OFF_LATCH: begin
               cmd.op = op_write;
               cmd.data = lane_merge(cmd.latch_q, w_data_ff, w_strb_ff);
            end
            `GP_OFF_SET: cmd.op = op_set;
            `GP_OFF_CLEAR: cmd.op = op_clear;
            `GP_OFF_TOGGLE: cmd.op = op_toggle;
            `GP_OFF_DIR: begin
               cmd.dir_we = 1'b1;
               cmd.data = lane_merge(cmd.dir_q, w_data_ff, w_strb_ff);
            end
            default: cmd.op = op_none;
         endcase
      end
   end

   // read channel, aliases read zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= `GP_REG_RESET;
         rresp <= `GP_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= is_mapped(araddr) ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
         unique case (araddr)
            `GP_OFF_LATCH: rdata <= cmd.latch_q;
            `GP_OFF_INPUT: rdata <= cmd.input_q;
            `GP_OFF_DIR: rdata <= cmd.dir_q;
            default: rdata <= 32'h00000000;
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   a_bad_write_err: assert property (@(posedge aclk) disable iff (!aresetn)
      do_write && !is_mapped(aw_addr_ff) |=> bvalid && bresp == `GP_RESP_SLVERR)
      else $error("unmapped write not answered with slverr");
   a_alias_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      arvalid && arready && (araddr == `GP_OFF_SET || araddr == `GP_OFF_TOGGLE) |=> rdata == 32'h00000000)
      else $error("alias read not zero");
endmodule

// >>> core/gpio_port.sv
// top of the general purpose io port: axi4-lite registers, latch, direction and input capture
// Functional notes
// - latch one drives pin high as output
// - unbonded latch bits read undefined
// - set alias forces written ones high
// - clear alias forces written ones low
// - toggle alias inverts written ones
// - input reads zero unimplemented or nondigital
// - disabled port control freezes input bits
// - direction one output, zero input
// - input is synchronized filtered pin level
// - synchronizers shared, stopped when disabled
// - gpio output pin equals latch bit
// - register writes work with port control off
// - one alias write changes many bits
// - outputs change on rising clock edge
// - unmapped offset gives bus error
`timescale 1ns/10ps
`include "gpio_port_cfg.svh"
module gpio_port (
   input wire logic aclk,
   input wire logic aresetn,
   input wire gpio_port_pkg::addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire gpio_port_pkg::word_t s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output gpio_port_pkg::resp_t s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire gpio_port_pkg::addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output gpio_port_pkg::word_t s_axi_rdata,
   output gpio_port_pkg::resp_t s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire gpio_port_pkg::word_t pin_filtered,
   input wire gpio_port_pkg::word_t pin_gpio_func,
   input wire gpio_port_pkg::word_t pin_digital,
   input wire logic port_ctrl_enable,
   output gpio_port_pkg::word_t pin_out,
   output gpio_port_pkg::word_t pin_out_en_n
);
   import gpio_port_pkg::*;

   latch_cmd_if cmd ();
   word_t output_latch_ff;
   word_t pin_direction_ff;
   word_t input_level_ff;
   word_t pin_out_ff;
   word_t pin_oe_n_ff;
   word_t nxt_output_latch;
   word_t nxt_pin_out;
   word_t nxt_pin_oe_n;
   word_t nxt_input_level;

   // bus slave front end; its registered outputs go straight to ports
   gpio_axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .cmd(cmd.slave)
   );

   // apply a latch command, all 32 bits in one write
   function automatic word_t latch_apply(input word_t cur, input latch_op_e op, input word_t d);
      word_t res;
      res = cur;
      unique case (op)
         op_none: res = cur;
         op_write: res = d;
         op_set: res = cur | d;
         op_clear: res = cur & ~d;
         op_toggle: res = cur ^ d;
         default: res = cur;
      endcase
      return res;
   endfunction

   assign nxt_output_latch = latch_apply(output_latch_ff, cmd.op, cmd.data);

   // output latch update, independent of port control enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_latch_ff <= `GP_REG_RESET;
      end else begin
         output_latch_ff <= nxt_output_latch;
      end
   end

   // direction register update, independent of port control enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_direction_ff <= `GP_REG_RESET;
      end else if (cmd.dir_we) begin
         pin_direction_ff <= cmd.data;
      end
   end

   // input capture: filtered synchronized level, zeroed where not digital or not present
   assign nxt_input_level = pin_filtered & pin_digital & `GP_PIN_IMPL;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         input_level_ff <= `GP_REG_RESET;
      end else if (port_ctrl_enable) begin
         input_level_ff <= nxt_input_level;
      end
   end

   // pin drive: gpio pins with direction one drive the latch level
   assign nxt_pin_oe_n = ~(pin_gpio_func & pin_direction_ff);
   assign nxt_pin_out = output_latch_ff & pin_gpio_func & pin_direction_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_ff <= 32'h00000000;
         pin_oe_n_ff <= `GP_OE_N_RESET;
      end else begin
         pin_out_ff <= nxt_pin_out;
         pin_oe_n_ff <= nxt_pin_oe_n;
      end
   end

   assign pin_out = pin_out_ff;
   assign pin_out_en_n = pin_oe_n_ff;
   assign cmd.latch_q = output_latch_ff;
   assign cmd.dir_q = pin_direction_ff;
   assign cmd.input_q = input_level_ff;

   a_set_forces_one: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd.op == op_set |=> (output_latch_ff & $past(cmd.data)) == $past(cmd.data)
         && (output_latch_ff & ~$past(cmd.data)) == ($past(output_latch_ff) & ~$past(cmd.data)))
      else $error("set alias did not force ones");
   a_clear_forces_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd.op == op_clear |=> (output_latch_ff & $past(cmd.data)) == 32'h00000000
         && (output_latch_ff & ~$past(cmd.data)) == ($past(output_latch_ff) & ~$past(cmd.data)))
      else $error("clear alias did not force zeros");
   a_toggle_inverts: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd.op == op_toggle |=> output_latch_ff == ($past(output_latch_ff) ^ $past(cmd.data)))
      else $error("toggle alias did not invert");
   a_input_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
      !port_ctrl_enable |=> $stable(input_level_ff))
      else $error("input changed while port control disabled");
   a_input_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      port_ctrl_enable |=> (input_level_ff & ~$past(pin_digital)) == 32'h00000000)
      else $error("nondigital pin read nonzero");
   a_pin_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> (pin_out & ~pin_out_en_n) == ($past(output_latch_ff) & ~pin_out_en_n))
      else $error("driven pin does not match latch");
   a_dir_enables: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> pin_out_en_n == ~($past(pin_gpio_func) & $past(pin_direction_ff)))
      else $error("output enable not from direction");
   a_dir_write_off: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd.dir_we && !port_ctrl_enable |=> pin_direction_ff == $past(cmd.data))
      else $error("direction write lost while port control off");
endmodule

// >>> verification/pin_side_model.sv
// model of the pin pads and port-control synchronizers facing the io port
`timescale 1ns/10ps
module pin_side_model (
   input wire logic aclk,
   input wire gpio_port_pkg::word_t pin_out,
   input wire gpio_port_pkg::word_t pin_out_en_n,
   input wire gpio_port_pkg::word_t ext_level,
   input wire logic port_ctrl_enable,
   output gpio_port_pkg::word_t pin_filtered
);
   import gpio_port_pkg::*;
   word_t pad;
   word_t sync1_ff = '0;
   word_t sync2_ff = '0;
   // pad level: own driver where enabled, otherwise the outside source
   assign pad = (pin_out & ~pin_out_en_n) | (ext_level & pin_out_en_n);
   // two stage synchronizer, frozen while port control is off to save power
   always @(posedge aclk) begin
      if (port_ctrl_enable) begin
         sync1_ff <= pad;
         sync2_ff <= sync1_ff;
      end
   end
   assign pin_filtered = sync2_ff;
endmodule

// >>> verification/general_purpose_io_port_bench.sv
// register-level testbench of the general purpose io port
`timescale 1ns/10ps
`include "gpio_port_cfg.svh"
module general_purpose_io_port_bench;
   import gpio_port_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   addr_t awaddr = '0, araddr = '0;
   word_t wdata = '0, ext = '0, func = '0, dig = '0, latch = '0, drv = '0, held;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pen = 0;
   logic awready, wready, bvalid, arready, rvalid;
   resp_t bresp, rresp;
   word_t rdata, pin_out, pin_out_en_n, pin_filt;
   int mismatches = 0, samples_checked = 0, cyc = 0;
   addr_t offs [6] = '{`GP_OFF_LATCH, `GP_OFF_SET, `GP_OFF_CLEAR, `GP_OFF_TOGGLE, `GP_OFF_INPUT, `GP_OFF_DIR};
   always #5 aclk = ~aclk;
   gpio_port i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_filtered(pin_filt),
      .pin_gpio_func(func), .pin_digital(dig), .port_ctrl_enable(pen), .pin_out(pin_out),
      .pin_out_en_n(pin_out_en_n));
   pin_side_model i_pins (.aclk(aclk), .pin_out(pin_out), .pin_out_en_n(pin_out_en_n), .ext_level(ext),
      .port_ctrl_enable(pen), .pin_filtered(pin_filt));
   // verdict and end of run
   task close_out;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // one comparison, counted
   task chk(input word_t got, input word_t exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // axi4-lite write, address and data offered together
   task wr(input addr_t a, input word_t d, input resp_t e);
      logic done;
      done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bvalid && bready) begin
            done = 1;
            bready <= 0;
            chk({30'h0, bresp}, {30'h0, e});
         end
      end
   endtask
   // axi4-lite read with expected data and response
   task rd(input addr_t a, input word_t x, input resp_t e);
      logic done;
      done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 0;
         if (rvalid && rready) begin
            done = 1;
            rready <= 0;
            chk(rdata, x);
            chk({30'h0, rresp}, {30'h0, e});
         end
      end
   endtask
   // latch update through one register, then read back the latch
   task upd(input addr_t a, input word_t d);
      case (a)
         `GP_OFF_SET: latch = latch | d;
         `GP_OFF_CLEAR: latch = latch & ~d;
         `GP_OFF_TOGGLE: latch = latch ^ d;
         default: latch = d;
      endcase
      wr(a, d, `GP_RESP_OKAY);
      rd(`GP_OFF_LATCH, latch, `GP_RESP_OKAY);
   endtask
   // cut a hang short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         mismatches = mismatches + 1;
         close_out;
      end
   end
   initial begin
      repeat (3) @(posedge aclk);
      chk(pin_out_en_n, 32'hFFFFFFFF);
      aresetn <= 1;
      for (int i = 0; i < 6; i++) rd(offs[i], 32'h0, `GP_RESP_OKAY);
      $display("test reset values done");
      upd(`GP_OFF_LATCH, 32'hA5A50F0F);
      upd(`GP_OFF_SET, 32'h000000F0);
      upd(`GP_OFF_CLEAR, 32'h0F00000F);
      upd(`GP_OFF_TOGGLE, 32'hFFFF0000);
      for (int i = 1; i < 4; i++) rd(offs[i], 32'h0, `GP_RESP_OKAY);
      $display("test latch aliases done");
      func <= 32'hFFFFFFF0;
      wr(`GP_OFF_DIR, 32'h00FF00FF, `GP_RESP_OKAY);
      drv = 32'h00FF00F0;
      rd(`GP_OFF_DIR, 32'h00FF00FF, `GP_RESP_OKAY);
      @(posedge aclk);
      #1;
      chk(pin_out, latch & drv);
      chk(pin_out_en_n, ~drv);
      $display("test direction done");
      @(posedge aclk);
      ext <= 32'h12345678;
      dig <= 32'hFFFF0FFF;
      pen <= 1;
      repeat (4) @(posedge aclk);
      held = ((latch & drv) | (32'h12345678 & ~drv)) & 32'hFFFF0FFF;
      rd(`GP_OFF_INPUT, held, `GP_RESP_OKAY);
      @(posedge aclk);
      pen <= 0;
      ext <= 32'hEDCBA987;
      dig <= 32'h00000000;
      upd(`GP_OFF_SET, 32'h0000FF00);
      wr(`GP_OFF_DIR, 32'h0, `GP_RESP_OKAY);
      rd(`GP_OFF_DIR, 32'h0, `GP_RESP_OKAY);
      repeat (4) @(posedge aclk);
      rd(`GP_OFF_INPUT, held, `GP_RESP_OKAY);
      $display("test input capture done");
      wstrb <= 4'h1;
      latch = latch ^ 32'h000000FF;
      wr(`GP_OFF_TOGGLE, 32'hFFFFFFFF, `GP_RESP_OKAY);
      wstrb <= 4'hF;
      wr(12'h018, 32'hFFFFFFFF, `GP_RESP_SLVERR);
      wr(12'h002, 32'hFFFFFFFF, `GP_RESP_SLVERR);
      rd(12'h018, 32'h0, `GP_RESP_SLVERR);
      rd(12'h00D, 32'h0, `GP_RESP_SLVERR);
      rd(`GP_OFF_LATCH, latch, `GP_RESP_OKAY);
      $display("test unmapped done");
      @(posedge aclk);
      aresetn <= 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1;
      rd(`GP_OFF_LATCH, 32'h0, `GP_RESP_OKAY);
      $display("test second reset done");
      close_out;
   end
endmodule
